//--- logic/tws_slave_tx.v
/*
 Two-wire slave transmitter with status sequencing, bus error recovery,
 Avalon-MM register slave and masked sticky interrupt.
 Assumes the external master drives the bus clock; the bus lines are
 open-drain with outside pull-ups. The arbitration-lost entry comes from
 a neighbouring master engine as a same-clock pulse.
*/
// Contract
// - Own address with read, acked: status A8, flag set.
// - In A8/B0/B8 load byte; ack enable picks last or normal.
// - Arbitration lost then own read address: status B0.
// - Byte sent and ACK received: status B8, flag set.
// - Byte sent and NOT ACK received: status C0, flag set.
// - Last byte answered with ACK: status C8.
// - After C0/C8 go not-addressed; ack enable gates recognition.
// - Start request on clear in C0/C8: START when bus free.
// - Flag clear: status reads F8.
// - Misplaced START/STOP: status 00, flag set.
// - Recovery: stop plus flag write; stop self-clears. Here a flag write in status 00 recovers without the stop bit.
// - Recovery releases both lines, sends no STOP.
// - Status prescaler bits read as zero.
// - Read bit enters transmit; write bit enters receive.
// - After last byte ignore master; it reads all ones.
// - Address register: seven-bit address high, general call bit low.
`timescale 1ns/100ps
`default_nettype none
`include "tws_map.vh"
module tws_slave_tx (
    input wire core_clk,
    input wire sys_rst,
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire scl_in,
    output reg scl_oe_n,
    input wire sda_in,
    output reg sda_oe_n,
    input wire arb_lost,
    output reg start_pending,
    output reg srx_enter,
    output reg irq
);
    // ========================================
    // Bus line sampling and conditions
    wire [1:0] pins;
    reg scl_d_ff, sda_d_ff;
    tws_sync #(.W(2)) u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in({scl_in, sda_in}),
        .sync_out(pins)
    );
    wire scl_s = pins[1];
    wire sda_s = pins[0];
    wire scl_rise = scl_s & ~scl_d_ff;
    wire scl_fall = ~scl_s & scl_d_ff;
    wire start_cond = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    wire stop_cond = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

    // ========================================
    // State and registers
    localparam S_IDLE = 3'd0;
    localparam S_ADDR = 3'd1;
    localparam S_AACK = 3'd2;
    localparam S_TX = 3'd3;
    localparam S_MACK = 3'd4;
    localparam S_WAIT = 3'd5;
    localparam S_IGN = 3'd6;

    reg [2:0] state_ff;
    reg [7:0] status_ff, byte_buffer_ff, own_address_reg_ff, shift_ff;
    reg [3:0] bit_ff;
    reg done_ff, ack_enable_ff, start_req_ff, stop_req_ff, enable_ff;
    reg last_ff, arb_ff, bus_busy_ff, ack_drive_ff;
    reg [1:0] irq_st_ff, irq_msk_ff;

    function is_reg;
        input [4:0] a;
        input [4:0] off;
        is_reg = (a == off);
    endfunction

    wire wr = avs_write & ~avs_waitrequest;
    wire ctl_wr = wr & is_reg(avs_address, {1'b0, `TWS_OFF_CTRL}) &
        avs_byteenable[0];
    wire clr_done = ctl_wr & avs_writedata[`TWS_CTL_DONE];
    wire addr_hit = (shift_ff[7:1] == own_address_reg_ff[7:1]) ||
        (shift_ff[7:1] == 7'h00 && own_address_reg_ff[0]);

    // ========================================
    // Sequencer
    always @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff <= S_IDLE;
            status_ff <= `TWS_ST_IDLE;
            bit_ff <= 4'h0;
            shift_ff <= 8'h00;
            done_ff <= 1'b0;
            last_ff <= 1'b0;
            arb_ff <= 1'b0;
            bus_busy_ff <= 1'b0;
            ack_drive_ff <= 1'b0;
            start_pending <= 1'b0;
            srx_enter <= 1'b0;
            stop_req_ff <= 1'b0;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
            srx_enter <= 1'b0;
            if (arb_lost)
                arb_ff <= 1'b1;
            if (start_cond)
                bus_busy_ff <= 1'b1;
            else if (stop_cond)
                bus_busy_ff <= 1'b0;
            if (start_pending && !bus_busy_ff)
                start_pending <= 1'b0;
            if (ctl_wr)
                stop_req_ff <= avs_writedata[`TWS_CTL_STOP];
            // Flag writes outside a wait must not stall the bit sequencer
            if (clr_done && state_ff == S_WAIT) begin
                done_ff <= 1'b0;
                status_ff <= `TWS_ST_IDLE;
                if (status_ff == `TWS_ST_BUS_ERR) begin
                    state_ff <= S_IDLE;
                    stop_req_ff <= 1'b0;
                    ack_drive_ff <= 1'b0;
                end else if (status_ff == `TWS_ST_DATA_NACK ||
                        status_ff == `TWS_ST_LAST_ACK) begin
                    state_ff <= S_IDLE;
                    if (avs_writedata[`TWS_CTL_START])
                        start_pending <= 1'b1;
                end else if (state_ff == S_WAIT) begin
                    shift_ff <= byte_buffer_ff;
                    last_ff <= ~avs_writedata[`TWS_CTL_ACK];
                    bit_ff <= 4'h0;
                    state_ff <= S_TX;
                end
            end else if (!enable_ff) begin
                state_ff <= S_IDLE;
            end else if ((start_cond || stop_cond) && (state_ff == S_ADDR ||
                    state_ff == S_TX || state_ff == S_MACK) && bit_ff != 4'h0) begin
                status_ff <= `TWS_ST_BUS_ERR;
                done_ff <= 1'b1;
                state_ff <= S_WAIT;
                ack_drive_ff <= 1'b0;
            end else if (start_cond) begin
                state_ff <= S_ADDR;
                bit_ff <= 4'h0;
            end else if (stop_cond && state_ff != S_WAIT) begin
                state_ff <= S_IDLE;
                arb_ff <= 1'b0;
            end else begin
                case (state_ff)
                    S_ADDR: if (scl_rise) begin
                        shift_ff <= {shift_ff[6:0], sda_s};
                        bit_ff <= bit_ff + 4'h1;
                    end else if (scl_fall && bit_ff == 4'h8) begin
                        if (addr_hit && ack_enable_ff) begin
                            ack_drive_ff <= 1'b1;
                            state_ff <= S_AACK;
                        end else
                            state_ff <= S_IGN;
                    end
                    S_AACK: if (scl_fall) begin
                        ack_drive_ff <= 1'b0;
                        if (shift_ff[0]) begin
                            status_ff <= arb_ff ? `TWS_ST_ARB_R :
                                `TWS_ST_ADDRESS_WITH_READ;
                            done_ff <= 1'b1;
                            arb_ff <= 1'b0;
                            state_ff <= S_WAIT;
                        end else begin
                            srx_enter <= 1'b1;
                            state_ff <= S_IGN;
                        end
                    end
                    S_TX: if (scl_fall) begin
                        if (bit_ff == 4'h7)
                            state_ff <= S_MACK;
                        else begin
                            shift_ff <= {shift_ff[6:0], 1'b1};
                            bit_ff <= bit_ff + 4'h1;
                        end
                    end
                    S_MACK: if (scl_rise) begin
                        done_ff <= 1'b1;
                        state_ff <= S_WAIT;
                        if (sda_s)
                            status_ff <= `TWS_ST_DATA_NACK;
                        else if (last_ff)
                            status_ff <= `TWS_ST_LAST_ACK;
                        else
                            status_ff <= `TWS_ST_DATA_ACK;
                    end
                    default: ;
                endcase
            end
        end
    end

    // ========================================
    // Open-drain outputs
    // ignored master sees ones
    wire nxt_sda_oe_n = ~(ack_drive_ff | (state_ff == S_TX &&
        !shift_ff[7] && bit_ff != 4'h8));
    wire stretch = done_ff && state_ff == S_WAIT &&
        status_ff != `TWS_ST_BUS_ERR &&
        status_ff != `TWS_ST_DATA_NACK &&
        status_ff != `TWS_ST_LAST_ACK && !scl_s;
    // Data settles a cycle before the clock is let go
    wire hold_scl = ~scl_oe_n & (nxt_sda_oe_n != sda_oe_n);
    always @(posedge core_clk) begin
        if (sys_rst) begin
            sda_oe_n <= 1'b1;
            scl_oe_n <= 1'b1;
        end else begin
            sda_oe_n <= nxt_sda_oe_n;
            scl_oe_n <= ~(stretch | hold_scl);
        end
    end

    // ========================================
    // Register slave, interrupt
    reg done_d_ff;
    wire [1:0] irq_ev;
    assign irq_ev[`TWS_IRQ_DONE] = done_ff & ~done_d_ff;
    assign irq_ev[`TWS_IRQ_ERR] = (status_ff == `TWS_ST_BUS_ERR) &
        irq_ev[`TWS_IRQ_DONE];
    always @(posedge core_clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            byte_buffer_ff <= 8'hFF;
            own_address_reg_ff <= 8'h00;
            ack_enable_ff <= 1'b0;
            start_req_ff <= 1'b0;
            enable_ff <= 1'b0;
            irq_st_ff <= 2'b00;
            irq_msk_ff <= 2'b00;
            irq <= 1'b0;
            done_d_ff <= 1'b0;
        end else begin
            done_d_ff <= done_ff;
            // One wait cycle per access
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if (ctl_wr) begin
                ack_enable_ff <= avs_writedata[`TWS_CTL_ACK];
                start_req_ff <= avs_writedata[`TWS_CTL_START];
                enable_ff <= avs_writedata[`TWS_CTL_EN];
            end
            if (wr && avs_byteenable[0]) begin
                if (is_reg(avs_address, {1'b0, `TWS_OFF_DATA}))
                    byte_buffer_ff <= avs_writedata[7:0];
                if (is_reg(avs_address, {1'b0, `TWS_OFF_ADDR}))
                    own_address_reg_ff <= avs_writedata[7:0];
                if (is_reg(avs_address, `TWS_OFF_IRQ_MSK))
                    irq_msk_ff <= avs_writedata[1:0];
            end
            // Set wins over write-one clear
            irq_st_ff <= irq_ev | (irq_st_ff &
                ~((wr && avs_byteenable[0] &&
                is_reg(avs_address, `TWS_OFF_IRQ_ST)) ?
                avs_writedata[1:0] : 2'b00));
            irq <= |(irq_st_ff & irq_msk_ff);
            avs_readdata <= 32'h0000_0000;
            if (avs_read && avs_waitrequest) begin
                case (avs_address)
                    {1'b0, `TWS_OFF_CTRL}: avs_readdata <= {24'h0000_00,
                        done_ff, ack_enable_ff, start_req_ff, stop_req_ff,
                        1'b0, enable_ff, 2'b00};
                    {1'b0, `TWS_OFF_STAT}: avs_readdata <=
                        {24'h0000_00, status_ff[7:3], 3'b000};
                    {1'b0, `TWS_OFF_DATA}: avs_readdata <=
                        {24'h0000_00, byte_buffer_ff};
                    {1'b0, `TWS_OFF_ADDR}: avs_readdata <=
                        {24'h0000_00, own_address_reg_ff};
                    `TWS_OFF_IRQ_ST: avs_readdata <= {30'h0000_0000, irq_st_ff};
                    `TWS_OFF_IRQ_MSK: avs_readdata <= {30'h0000_0000, irq_msk_ff};
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // tws_slave_tx
`default_nettype wire

//--- inc/tws_map.vh
/*
 Register offsets, field positions, status codes and interrupt bit positions for the
 two-wire slave transmitter block. Assumes a 32-bit Avalon-MM register bus.
*/
`ifndef TWS_MAP_VH
`define TWS_MAP_VH
// Register byte offsets
`define TWS_OFF_CTRL 4'h0
`define TWS_OFF_STAT 4'h4
`define TWS_OFF_DATA 4'h8
`define TWS_OFF_ADDR 4'hC
`define TWS_OFF_IRQ_ST 5'h10
`define TWS_OFF_IRQ_MSK 5'h14
// Control bit positions
`define TWS_CTL_DONE 7
`define TWS_CTL_ACK 6
`define TWS_CTL_START 5
`define TWS_CTL_STOP 4
`define TWS_CTL_EN 2
// Status codes
`define TWS_ST_ADDRESS_WITH_READ 8'hA8
`define TWS_ST_ARB_R 8'hB0
`define TWS_ST_DATA_ACK 8'hB8
`define TWS_ST_DATA_NACK 8'hC0
`define TWS_ST_LAST_ACK 8'hC8
`define TWS_ST_IDLE 8'hF8
`define TWS_ST_BUS_ERR 8'h00
// Interrupt status bit positions
`define TWS_IRQ_DONE 0
`define TWS_IRQ_ERR 1
`define TWS_IRQ_W 2
`endif

//--- logic/tws_sync.v
/*
 Two-flop synchroniser for a vector of pin levels.
 Assumes inputs are asynchronous to core_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module tws_sync #(
    parameter W = 2
) (
    input wire core_clk,
    input wire sys_rst,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] meta_ff;
    // Idle bus lines read high
    always @(posedge core_clk) begin
        if (sys_rst) begin
            meta_ff <= {W{1'b1}};
            sync_out <= {W{1'b1}};
        end else begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule // tws_sync
`default_nettype wire

//--- dv/tws_slave_tx_monitor.sv
/* Port checker for tws_slave_tx.
   Assumes it is bound onto every instance of tws_slave_tx. */
`timescale 1ns/100ps
`default_nettype none
// ============================================
// Port checks
module tws_chk (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic scl_in,
    input wire logic sda_oe_n,
    input wire logic start_pending,
    input wire logic srx_enter,
    input wire logic irq
);
default clocking @(posedge core_clk); endclocking
default disable iff (sys_rst);
bus_answer_a: assert property (avs_waitrequest && (avs_read || avs_write)
    |=> !avs_waitrequest) else $error("bus request not answered");
wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held too long");
idle_zero_a: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("read data outside answer");
status_low_a: assert property (
    avs_read && !avs_waitrequest && avs_address == 5'h04
    |-> avs_readdata[2:0] == 3'h0 && avs_readdata[31:8] == 24'h0)
    else $error("status low bits set");
unmap_zero_a: assert property (avs_read && !avs_waitrequest
    && avs_address > 5'h14 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
start_cause_a: assert property ($rose(start_pending) |->
    $past(avs_write && avs_address == 5'h00 && avs_writedata[5]))
    else $error("start request without write");
irq_drop_a: assert property ($fell(irq) |->
    $past(avs_write) || $past(avs_write, 2))
    else $error("interrupt dropped without write");
srx_pulse_a: assert property (srx_enter |=> !srx_enter)
    else $error("receive entry not a pulse");
sda_safe_a: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data line moved while clock high");
endmodule // tws_chk
bind tws_slave_tx tws_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .scl_in(scl_in), .sda_oe_n(sda_oe_n), .start_pending(start_pending),
    .srx_enter(srx_enter), .irq(irq));
`default_nettype wire

//--- dv/tws_mst_model.sv
/* Behavioural two-wire master receiver, 160 ns bit period.
   Assumes open-drain lines resolved by the bench with pull-ups. */
`timescale 1ns/100ps
`default_nettype none
// ============================================
// Master receiver
module tws_mst_model (
    output logic scl_drv,
    output logic sda_drv,
    input wire logic scl_line,
    input wire logic sda_line
);
initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
end
task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    #40 scl_drv = 1'b1;
    wait (scl_line === 1'b1);
    #43 r = sda_line;
    #40 scl_drv = 1'b0;
    #37;
endtask
task automatic start_c;
    #3 sda_drv = 1'b1;
    scl_drv = 1'b1;
    #40 sda_drv = 1'b0;
    #40 scl_drv = 1'b0;
    #40;
endtask
task automatic stop_c;
    sda_drv = 1'b0;
    #40 scl_drv = 1'b1;
    #40 sda_drv = 1'b1;
    #40;
endtask
task automatic byte_out(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
endtask
task automatic byte_in(output logic [7:0] d, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!ack, r);
endtask
endmodule // tws_mst_model
`default_nettype wire

//--- dv/two_wire_slave_tx_status_tb.sv
/* Self-checking bench for tws_slave_tx.
   Assumes tws_mst_model on the bus and the bound port checker. */
`timescale 1ns/100ps
`default_nettype none
// ============================================
// Bench
module two_wire_slave_tx_status_tb;
logic core_clk, sys_rst, avs_read, avs_write, avs_waitrequest, a;
logic arb_lost;
logic [4:0] avs_address;
logic [31:0] avs_writedata, avs_readdata;
logic scl_oe_n, sda_oe_n, start_pending, srx_enter, irq, scl_drv, sda_drv;
logic [7:0] d;
int failures = 0, compares = 0, cyc = 0, srx_seen = 0;
wire logic scl_line = scl_drv & scl_oe_n;
wire logic sda_line = sda_drv & sda_oe_n;
tws_slave_tx u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scl_in(scl_line),
    .scl_oe_n(scl_oe_n), .sda_in(sda_line), .sda_oe_n(sda_oe_n),
    .arb_lost(arb_lost), .start_pending(start_pending),
    .srx_enter(srx_enter), .irq(irq));
tws_mst_model u_mst (.scl_drv(scl_drv), .sda_drv(sda_drv),
    .scl_line(scl_line), .sda_line(sda_line));
task automatic finish_test;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
        failures++;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
endtask
task automatic acc(input logic w, input logic [4:0] ad,
    input logic [31:0] wd, output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= ad;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
endtask
task automatic wr(input logic [4:0] ad, input logic [31:0] wd);
    logic [31:0] q;
    acc(1'b1, ad, wd, q);
endtask
task automatic rd_chk(input logic [4:0] ad, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, ad, 32'h0, q);
    chk(q, e);
endtask
task automatic irq_is(input logic e);
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq}, {31'h0, e});
endtask
task automatic wait_stat(input logic [7:0] e);
    while (irq !== 1'b1) @(posedge core_clk);
    wr(5'h10, 32'h0000_0001);
    rd_chk(5'h04, {24'h0, e});
endtask
task automatic send(input logic [7:0] b, input logic [7:0] e,
    input logic [31:0] c, input logic ack);
    wr(5'h08, {24'h0, b});
    fork
        u_mst.byte_in(d, ack);
        wr(5'h00, c);
    join
    chk({24'h0, d}, {24'h0, e});
endtask
initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
end
always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (srx_enter === 1'b1) srx_seen <= srx_seen + 1;
    if (cyc == 30000) begin
        failures++;
        finish_test;
    end
end
initial begin
    {sys_rst, avs_read, avs_write, avs_address, avs_writedata} = '1;
    {avs_read, avs_write, arb_lost} = 3'b000;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd_chk(5'h04, 32'h0000_00F8);
    rd_chk(5'h18, 32'h0);
    wr(5'h0C, 32'h0000_0055);
    wr(5'h14, 32'h0000_0003);
    wr(5'h00, 32'h0000_0044);
    // Read: normal byte, last byte acked, then ones
    u_mst.start_c();
    u_mst.byte_out(8'h55, a);
    chk({31'h0, a}, 32'h1);
    wait_stat(8'hA8);
    send(8'h3C, 8'h3C, 32'h0000_00C4, 1'b1);
    wait_stat(8'hB8);
    send(8'h81, 8'h81, 32'h0000_0084, 1'b1);
    wait_stat(8'hC8);
    // Buffer holds zeros; an ignored master must still read ones
    send(8'h00, 8'hFF, 32'h0000_00C4, 1'b0);
    u_mst.stop_c();
    chk(srx_seen, 32'h0);
    // Lost arbitration, nack, then start request
    u_mst.start_c();
    @(posedge core_clk) arb_lost <= 1'b1;
    @(posedge core_clk) arb_lost <= 1'b0;
    u_mst.byte_out(8'h55, a);
    chk({31'h0, a}, 32'h1);
    wait_stat(8'hB0);
    send(8'hA5, 8'hA5, 32'h0000_00C4, 1'b0);
    wait_stat(8'hC0);
    wr(5'h00, 32'h0000_00E4);
    repeat (2) @(posedge core_clk);
    chk({31'h0, start_pending}, 32'h1);
    u_mst.stop_c();
    wr(5'h00, 32'h0000_0004);
    chk({31'h0, start_pending}, 32'h0);
    u_mst.start_c();
    u_mst.byte_out(8'h55, a);
    chk({31'h0, a}, 32'h0);
    u_mst.stop_c();
    wr(5'h00, 32'h0000_0044);
    // Misplaced stop in address byte
    u_mst.start_c();
    for (int i = 0; i < 3; i++) u_mst.bit_io(i[0], a);
    u_mst.stop_c();
    wait_stat(8'h00);
    wr(5'h14, 32'h0);
    irq_is(1'b0);
    wr(5'h14, 32'h0000_0003);
    irq_is(1'b1);
    wr(5'h10, 32'h0000_0003);
    irq_is(1'b0);
    wr(5'h00, 32'h0000_00D4);
    rd_chk(5'h00, 32'h0000_0044);
    rd_chk(5'h04, 32'h0000_00F8);
    chk({30'h0, scl_oe_n, sda_oe_n}, 32'h3);
    u_mst.start_c();
    u_mst.byte_out(8'h54, a);
    chk({31'h0, a}, 32'h1);
    u_mst.stop_c();
    chk(srx_seen, 32'h1);
    finish_test;
end
endmodule // two_wire_slave_tx_status_tb
`default_nettype wire
